// *** core/ctp_timer.sv ***
// Compact 10-bit timer with compare output and PWM, APB register slave
//
// How it works
// - 10-bit counter advances per selected clock edge
// - P compares top three bits, A all
// - Period codes 1..7 times 128, 0 overflow
// - On rise clears counter, fall holds it
// - No software write path to counter
// - Pause holds counter, resume from held value
// - Clock select picks system, divided, timebase or pin
// - Mode field picks compare, PWM or timer
// - Compare mode A match drives pin action
// - PWM output control forces level or waveform
// - Compare mode on rise restores initial output level
// - Level bit sets initial or active level
// - Same requested level gives no visible change
// - Polarity bit inverts pin in compare mode and in PWM output codes other than the hold code
// - Swap bit exchanges PWM period and duty
// - Clear-select picks A match or P match
// - PWM mode ignores clear-select bit
// - Timer mode holds last pin level
// - Counter read-only pair, compare A read/write
// - Low byte write goes to shared buffer
// - High byte read latches low into buffer
// - Clear-select one suppresses P flag
// - Duty not below period gives full duty
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps

module ctp_timer (
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	input  wire ctp_pkg::ctp_apb_req_t  apbReq,
	output ctp_pkg::ctp_apb_rsp_t       apbRsp,
	input  wire logic                   timerClockInPin,
	input  wire logic                   timebaseClock,
	output logic                        timerOutputPin,
	output logic                        matchAFlag,
	output logic                        matchPFlag
);
	import ctp_pkg::*;

	ctp_state_t                s_r;
	ctp_state_t                s_nxt;

	logic                      access;
	logic                      done;
	logic                      wrDone;
	logic                      rdDone;
	logic                      mapped;
	logic [DATA_W-1:0]         rdData;
	logic                      tick;
	logic                      onRise;
	logic                      running;
	logic [CNT_W:0]            inc;
	logic                      matchA;
	logic                      matchP;
	logic                      clearCnt;
	logic                      pwmMode;
	logic [CNT_W:0]            perTicks;
	logic [CNT_W:0]            pwmPeriod;
	logic [CNT_W:0]            pwmDuty;
	logic                      pwmActive;
	logic                      level;

	always_comb begin
		s_nxt = s_r;
		s_nxt.rsp.pready = 1'b0;
		access = apbReq.psel & apbReq.penable;
		done = access & s_r.rsp.pready;
		wrDone = done & apbReq.pwrite;
		rdDone = done & ~apbReq.pwrite;
		pwmMode = (s_r.ctl1.mode == MD_PWM);

		// Register read path
		mapped = 1'b1;
		rdData = '0;
		case (apbReq.paddr)
			OFS_CTL0: begin
				rdData[BYTE_W-1:0] = s_r.ctl0;
			end
			OFS_CTL1: begin
				rdData[BYTE_W-1:0] = s_r.ctl1;
			end
			OFS_CNTLO, OFS_CMPLO: begin
				rdData[BYTE_W-1:0] = s_r.byteBuf;
			end
			OFS_CNTHI: begin
				rdData[CNT_W-BYTE_W-1:0] = s_r.cnt[CNT_W-1:BYTE_W];
			end
			OFS_CMPHI: begin
				rdData[CNT_W-BYTE_W-1:0] = s_r.cmpA[CNT_W-1:BYTE_W];
			end
			OFS_FLAGS: begin
				rdData[FLAG_A_BIT] = s_r.flagA;
				rdData[FLAG_P_BIT] = s_r.flagP;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase

		// One wait state; answer and data from flops
		if (access && !s_r.rsp.pready) begin
			s_nxt.rsp.pready = 1'b1;
			s_nxt.rsp.pslverr = ~mapped;
			s_nxt.rsp.prdata = apbReq.pwrite ? '0 : rdData;
		end

		// Register write and read side effects
		if (wrDone) begin
			case (apbReq.paddr)
				OFS_CTL0: begin
					s_nxt.ctl0 = apbReq.pwdata[BYTE_W-1:0];
				end
				OFS_CTL1: begin
					s_nxt.ctl1 = apbReq.pwdata[BYTE_W-1:0];
				end
				OFS_CMPLO: begin
					s_nxt.byteBuf = apbReq.pwdata[BYTE_W-1:0];
				end
				OFS_CMPHI: begin
					s_nxt.cmpA = {apbReq.pwdata[CNT_W-BYTE_W-1:0],
						s_r.byteBuf};
				end
				// Flags clear by writing one
				OFS_FLAGS: begin
					if (apbReq.pwdata[FLAG_A_BIT]) begin
						s_nxt.flagA = 1'b0;
					end
					if (apbReq.pwdata[FLAG_P_BIT]) begin
						s_nxt.flagP = 1'b0;
					end
				end
				// counter pair has no write path
				default: begin
				end
			endcase
		end
		if (rdDone && apbReq.paddr == OFS_CNTHI) begin
			s_nxt.byteBuf = s_r.cnt[BYTE_W-1:0];
		end
		if (rdDone && apbReq.paddr == OFS_CMPHI) begin
			s_nxt.byteBuf = s_r.cmpA[BYTE_W-1:0];
		end

		s_nxt.extMeta = timerClockInPin;
		s_nxt.extSync = s_r.extMeta;
		s_nxt.extPrev = s_r.extSync;
		s_nxt.tbcPrev = timebaseClock;
		s_nxt.pre = s_r.pre + 1'b1;

		case (s_r.ctl0.clkSel)
			CK_SYS4: tick = (s_r.pre[1:0] == DIV4_END);
			CK_SYS: tick = 1'b1;
			CK_H16: tick = (s_r.pre[3:0] == DIV16_END);
			CK_H64: tick = (s_r.pre == DIV64_END);
			CK_TBC0, CK_TBC1: tick = timebaseClock & ~s_r.tbcPrev;
			CK_PINR: tick = s_r.extSync & ~s_r.extPrev;
			CK_PINF: tick = ~s_r.extSync & s_r.extPrev;
			default: tick = 1'b0;
		endcase

		s_nxt.onPrev = s_r.ctl0.on;
		onRise = s_r.ctl0.on & ~s_r.onPrev;
		running = s_r.ctl0.on & ~s_r.ctl0.pause & tick;
		inc = {1'b0, s_r.cnt} + 11'h001;

		perTicks = (s_r.ctl0.period == PER_OVERFLOW) ? FULL_PERIOD :
			{1'b0, s_r.ctl0.period, 7'h00};
		matchP = (s_r.ctl0.period == PER_OVERFLOW) ? inc[CNT_W] :
			(inc[CNT_W-1:PER_LSB] == s_r.ctl0.period &&
			inc[PER_LSB-1:0] == '0 && !inc[CNT_W]);
		// Zero compare value never flags A
		matchA = (s_r.cmpA != CNT_RESET) && !inc[CNT_W] &&
			(inc[CNT_W-1:0] == s_r.cmpA);

		if (pwmMode) begin
			clearCnt = s_r.ctl1.swap ? matchA : matchP;
		end else begin
			clearCnt = s_r.ctl1.clearSel ? matchA : matchP;
		end

		pwmPeriod = s_r.ctl1.swap ?
			((s_r.cmpA == CNT_RESET) ? FULL_PERIOD : {1'b0, s_r.cmpA}) :
			perTicks;
		pwmDuty = s_r.ctl1.swap ? perTicks : {1'b0, s_r.cmpA};
		pwmActive = (pwmDuty >= pwmPeriod) ||
			({1'b0, s_r.cnt} < pwmDuty);

		if (onRise) begin
			s_nxt.cnt = CNT_RESET;
			s_nxt.cmpLevel = s_r.ctl1.outLevel;
		end else if (running) begin
			s_nxt.cnt = clearCnt ? CNT_RESET : inc[CNT_W-1:0];
			if (matchA) begin
				s_nxt.flagA = 1'b1;
			end
			if (matchP && (pwmMode || !s_r.ctl1.clearSel)) begin
				s_nxt.flagP = 1'b1;
			end
			if (matchA && s_r.ctl1.mode == MD_CMP) begin
				case (s_r.ctl1.outCtl)
					IO_LOW: s_nxt.cmpLevel = 1'b0;
					IO_HIGH: s_nxt.cmpLevel = 1'b1;
					IO_TOGGLE: s_nxt.cmpLevel = ~s_r.cmpLevel;
					default: s_nxt.cmpLevel = s_r.cmpLevel;
				endcase
			end
		end

		if (pwmMode) begin
			case (s_r.ctl1.outCtl)
				IO_NONE: level = ~s_r.ctl1.outLevel;
				IO_LOW: level = s_r.ctl1.outLevel;
				IO_HIGH: level = pwmActive ? s_r.ctl1.outLevel :
					~s_r.ctl1.outLevel;
				// Undefined code holds the pin under either polarity
				default: level = s_r.pin ^ s_r.ctl1.polarity;
			endcase
		end else begin
			level = s_r.cmpLevel;
		end
		// timer mode keeps last pin level
		case (s_r.ctl1.mode)
			MD_CMP, MD_PWM: s_nxt.pin = level ^ s_r.ctl1.polarity;
			default: s_nxt.pin = s_r.pin;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign apbRsp = s_r.rsp;
	assign timerOutputPin = s_r.pin;
	assign matchAFlag = s_r.flagA;
	assign matchPFlag = s_r.flagP;

endmodule : ctp_timer

// *** shared/ctp_pkg.sv ***
// Shared types and constants for the compact 10-bit timer
package ctp_pkg;

	localparam int CNT_W = 10;
	localparam int PER_W = 3;
	localparam int PER_LSB = 7;
	localparam int BYTE_W = 8;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int PRE_W = 6;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTL0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTL1 = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CNTLO = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CNTHI = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_CMPLO = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CMPHI = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h18;

	localparam logic [BYTE_W-1:0] CTL_RESET = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;
	localparam logic [CNT_W:0] FULL_PERIOD = 11'h400;
	localparam logic [PER_W-1:0] PER_OVERFLOW = 3'h0;
	localparam int FLAG_A_BIT = 0;
	localparam int FLAG_P_BIT = 1;

	// Prescaler terminal counts
	localparam logic [1:0] DIV4_END = 2'h3;
	localparam logic [3:0] DIV16_END = 4'hf;
	localparam logic [5:0] DIV64_END = 6'h3f;

	typedef enum logic [2:0] {
		CK_SYS4 = 3'h0, CK_SYS = 3'h1, CK_H16 = 3'h2, CK_H64 = 3'h3,
		CK_TBC0 = 3'h4, CK_TBC1 = 3'h5, CK_PINR = 3'h6, CK_PINF = 3'h7
	} ctp_clk_t;

	typedef enum logic [1:0] {
		MD_CMP = 2'h0, MD_UNDEF = 2'h1, MD_PWM = 2'h2, MD_TMR = 2'h3
	} ctp_mode_t;

	typedef enum logic [1:0] {
		IO_NONE = 2'h0, IO_LOW = 2'h1, IO_HIGH = 2'h2, IO_TOGGLE = 2'h3
	} ctp_io_t;

	typedef struct packed {
		logic                   pause;
		ctp_clk_t               clkSel;
		logic                   on;
		logic [PER_W-1:0]       period;
	} ctp_ctl0_t;

	typedef struct packed {
		ctp_mode_t              mode;
		ctp_io_t                outCtl;
		logic                   outLevel;
		logic                   polarity;
		logic                   swap;
		logic                   clearSel;
	} ctp_ctl1_t;

	typedef struct packed {
		logic                   psel;
		logic                   penable;
		logic                   pwrite;
		logic [ADDR_W-1:0]      paddr;
		logic [DATA_W-1:0]      pwdata;
	} ctp_apb_req_t;

	typedef struct packed {
		logic                   pready;
		logic                   pslverr;
		logic [DATA_W-1:0]      prdata;
	} ctp_apb_rsp_t;

	typedef struct packed {
		ctp_ctl0_t              ctl0;
		ctp_ctl1_t              ctl1;
		logic [CNT_W-1:0]       cnt;
		logic [CNT_W-1:0]       cmpA;
		logic [BYTE_W-1:0]      byteBuf;
		logic                   flagA;
		logic                   flagP;
		logic                   cmpLevel;
		logic                   pin;
		logic                   onPrev;
		logic [PRE_W-1:0]       pre;
		logic                   extMeta;
		logic                   extSync;
		logic                   extPrev;
		logic                   tbcPrev;
		ctp_apb_rsp_t           rsp;
	} ctp_state_t;

endpackage : ctp_pkg

// *** verif/ctp_timer_properties.sv ***
// Port-level checks for the compact timer
`timescale 1ns/1ps
module ctp_timer_properties (
	input wire logic                  mclk,
	input wire logic                  sys_rst,
	input wire ctp_pkg::ctp_apb_req_t apbReq,
	input wire ctp_pkg::ctp_apb_rsp_t apbRsp,
	input wire logic                  timerOutputPin,
	input wire logic                  matchAFlag,
	input wire logic                  matchPFlag
);
	import ctp_pkg::*;
	logic       done;
	logic       wrDone;
	logic       clrA;
	logic       onSh_r;
	ctp_ctl1_t  c1Sh_r;
	logic [1:0] age_r;
	assign done = apbReq.psel && apbReq.penable && apbRsp.pready;
	assign wrDone = done && apbReq.pwrite;
	assign clrA = wrDone && apbReq.paddr == OFS_FLAGS && apbReq.pwdata[0];
	// Age skips the pin pipeline after control writes
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			onSh_r <= 1'b0;
			c1Sh_r <= '0;
			age_r <= 2'h0;
		end else if (wrDone && apbReq.paddr == OFS_CTL0) begin
			onSh_r <= apbReq.pwdata[3];
			age_r <= 2'h0;
		end else if (wrDone && apbReq.paddr == OFS_CTL1) begin
			c1Sh_r <= ctp_ctl1_t'(apbReq.pwdata[7:0]);
			age_r <= 2'h0;
		end else if (age_r != 2'h3) begin
			age_r <= age_r + 2'h1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence s_setup;
		apbReq.psel && !apbReq.penable;
	endsequence
	sequence s_onRise;
		wrDone && apbReq.paddr == OFS_CTL0 && apbReq.pwdata[3] && !onSh_r;
	endsequence
	a_access_two: assert property (s_setup |=> !apbRsp.pready ##1
		apbRsp.pready) else $error("pready late");
	a_unmapped_err: assert property (done && apbReq.paddr > OFS_FLAGS
		|-> apbRsp.pslverr && apbRsp.prdata == '0) else $error("bad slot");
	a_high_zero: assert property (done && !apbReq.pwrite &&
		(apbReq.paddr == OFS_CNTHI || apbReq.paddr == OFS_CMPHI)
		|-> apbRsp.prdata[31:2] == '0) else $error("high bits set");
	a_flag_sticky: assert property (matchAFlag && !clrA
		|=> matchAFlag) else $error("flag lost");
	a_p_quiet: assert property (c1Sh_r.clearSel && age_r == 2'h3 &&
		c1Sh_r.mode inside {MD_CMP, MD_TMR} && !matchPFlag
		|=> !matchPFlag) else $error("P flag set");
	a_on_level: assert property (s_onRise ##0 c1Sh_r.mode == MD_CMP
		|-> ##3 timerOutputPin == (c1Sh_r.outLevel ^ c1Sh_r.polarity))
		else $error("initial level wrong");
	a_pwm_force: assert property (c1Sh_r.mode == MD_PWM && onSh_r &&
		age_r == 2'h3 && c1Sh_r.outCtl inside {IO_NONE, IO_LOW}
		|-> timerOutputPin == ((c1Sh_r.outCtl == IO_LOW) ~^
		(c1Sh_r.outLevel ^ c1Sh_r.polarity))) else $error("forced pin");
	a_tmr_hold: assert property (c1Sh_r.mode == MD_TMR && age_r == 2'h3
		|=> $stable(timerOutputPin)) else $error("pin moved");
endmodule : ctp_timer_properties

bind ctp_timer ctp_timer_properties i_props (.mclk(mclk),
	.sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
	.timerOutputPin(timerOutputPin), .matchAFlag(matchAFlag),
	.matchPFlag(matchPFlag));

// *** verif/ctp_pin_model.sv ***
// External counter clock pin model
`timescale 1ns/1ps
module ctp_pin_model (
	input  wire logic mclk,
	output logic      pinLvl
);
	initial pinLvl = 1'b0;
	// Wide gaps so the two-flop sync sees every level
	task automatic toggle(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			pinLvl <= ~pinLvl;
			repeat (5) @(posedge mclk);
		end
		repeat (6) @(posedge mclk);
	endtask : toggle
endmodule : ctp_pin_model

// *** verif/compact_timer_pwm_10bit_test.sv ***
// Self-checking bench for the compact timer
`timescale 1ns/1ps
module compact_timer_pwm_10bit_test;
	import ctp_pkg::*;
	logic         mclk;
	logic         sys_rst;
	logic         tbc;
	ctp_apb_req_t req;
	ctp_apb_rsp_t rsp;
	logic         pin;
	logic         outPin;
	logic         flA;
	logic         flP;
	logic [32:0]  expQ[$];
	int           failures = 0;
	int           n_tests = 0;
	logic [9:0]   v;
	logic         lv;
	logic         pol;
	logic         ok;
	logic [1:0]   md[3] = '{2'h0, 2'h2, 2'h3};
	ctp_timer i_dut (.mclk(mclk), .sys_rst(sys_rst), .apbReq(req),
		.apbRsp(rsp), .timerClockInPin(pin), .timebaseClock(tbc),
		.timerOutputPin(outPin), .matchAFlag(flA), .matchPFlag(flP));
	ctp_pin_model i_pin (.mclk(mclk), .pinLvl(pin));
	always #25 mclk = ~mclk;
	always @(posedge mclk) if ($urandom_range(7) == 0) tbc <= ~tbc;
	task automatic chkRd(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chkRd
	// Caller waits for the falling edge, where outputs have settled
	task automatic chkPin(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chkPin
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [32:0] e);
		@(posedge mclk);
		req <= '{1'b1, 1'b0, w, a, d};
		if (!w) expQ.push_back(e);
		@(posedge mclk);
		req.penable <= 1'b1;
		@(posedge mclk);
		while (rsp.pready !== 1'b1) @(posedge mclk);
		req <= '0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d}, '0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		apb(1'b0, a, '0, e);
	endtask : rd
	task automatic rdCnt(input logic [9:0] e);
		rd(OFS_CNTHI, {31'h0, e[9:8]});
		rd(OFS_CNTLO, {25'h0, e[7:0]});
	endtask : rdCnt
	function automatic logic pinExp(input logic [1:0] m,
			input logic [1:0] io, input logic l, input logic p,
			input logic aft);
		logic r;
		if (m == 2'h2) r = (io == 2'h1 || (io == 2'h2 && !aft)) ? l : ~l;
		else if (!aft || io == 2'h0) r = l;
		else r = (io == 2'h3) ? ~l : io[1];
		return r ^ p;
	endfunction : pinExp
	task automatic conclude;
		$display("Checks %0d, failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	always @(posedge mclk) begin
		if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite)
			chkRd({rsp.pslverr, rsp.prdata}, expQ.pop_front());
	end
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		conclude();
	end
	initial begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		tbc = 1'b0;
		req = '0;
		void'($urandom(32'hd3ea));
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(OFS_CTL0, '0);
		rd(OFS_CTL1, '0);
		rd(OFS_CMPHI, '0);
		rd(OFS_CMPLO, '0);
		rd(8'h1c, {1'b1, 32'h0});
		wr(OFS_CNTLO, 8'hff);
		wr(OFS_CNTHI, 8'h03);
		rdCnt(10'h0);
		v = 10'($urandom);
		wr(OFS_CMPLO, v[7:0]);
		wr(OFS_CMPHI, {6'h0, v[9:8]});
		wr(OFS_CMPLO, ~v[7:0]);
		rd(OFS_CMPHI, {31'h0, v[9:8]});
		rd(OFS_CMPLO, {25'h0, v[7:0]});
		wr(OFS_CMPLO, 8'h00);
		wr(OFS_CMPHI, 8'h00);
		wr(OFS_CTL0, 8'h68);
		v = 10'($urandom_range(20));
		i_pin.toggle(2 * v + 1);
		rdCnt(v + 10'h1);
		wr(OFS_CTL0, 8'he8);
		i_pin.toggle(2);
		rdCnt(v + 10'h1);
		wr(OFS_CTL0, 8'h68);
		i_pin.toggle(2);
		rdCnt(v + 10'h2);
		wr(OFS_CTL0, 8'h60);
		i_pin.toggle(2);
		rdCnt(v + 10'h2);
		wr(OFS_CTL0, 8'h78);
		i_pin.toggle(1);
		rdCnt(10'h1);
		wr(OFS_CTL0, 8'h60);
		wr(OFS_CMPLO, 8'h05);
		wr(OFS_CMPHI, 8'h00);
		wr(OFS_CTL0, 8'h69);
		i_pin.toggle(254);
		@(negedge mclk);
		chkPin(flP, 1'b0);
		i_pin.toggle(2);
		@(negedge mclk);
		chkPin(flA, 1'b1);
		chkPin(flP, 1'b1);
		wr(OFS_FLAGS, 8'h03);
		@(negedge mclk);
		chkPin(flP, 1'b0);
		wr(OFS_CMPLO, 8'h03);
		wr(OFS_CMPHI, 8'h00);
		foreach (md[m]) begin
			for (int io = 0; io < 4; io++) begin
				lv = 1'($urandom);
				pol = 1'($urandom);
				ok = md[m] == 2'h0 || (md[m] == 2'h2 && io < 3);
				// Output settings only change while off
				wr(OFS_CTL0, 8'h61);
				wr(OFS_CTL1, {md[m], 2'(io), lv, pol, 2'h1});
				rd(OFS_CTL1, {25'h0, md[m], 2'(io), lv, pol, 2'h1});
				wr(OFS_CTL0, 8'h69);
				repeat (4) @(posedge mclk);
				@(negedge mclk);
				if (ok) chkPin(outPin, pinExp(md[m], 2'(io), lv, pol, 1'b0));
				i_pin.toggle(6);
				@(negedge mclk);
				if (ok) chkPin(outPin, pinExp(md[m], 2'(io), lv, pol, 1'b1));
				chkPin(flA, 1'b1);
				wr(OFS_FLAGS, 8'h01);
				@(negedge mclk);
				chkPin(flA, 1'b0);
			end
		end
		// Swapped roles: A sets period 256, code 1 sets duty 128
		wr(OFS_CTL0, 8'h61);
		wr(OFS_CMPLO, 8'h00);
		wr(OFS_CMPHI, 8'h01);
		wr(OFS_CTL1, 8'haa);
		wr(OFS_CTL0, 8'h69);
		i_pin.toggle(252);
		@(negedge mclk);
		chkPin(outPin, 1'b1);
		i_pin.toggle(8);
		@(negedge mclk);
		chkPin(outPin, 1'b0);
		// Duty 256 above period 128 stays active
		wr(OFS_CTL0, 8'h61);
		wr(OFS_CTL1, 8'ha8);
		wr(OFS_FLAGS, 8'h03);
		wr(OFS_CTL0, 8'h19);
		repeat (8) begin
			repeat ($urandom_range(40, 1)) @(posedge mclk);
			@(negedge mclk);
			chkPin(outPin, 1'b1);
		end
		repeat (140) @(posedge mclk);
		@(negedge mclk);
		chkPin(flP, 1'b1);
		conclude();
	end
endmodule : compact_timer_pwm_10bit_test
